//--- common/fault_status_regs.vh
`ifndef FAULT_STATUS_REGS_VH
`define FAULT_STATUS_REGS_VH

// byte address of the configurable fault status word
`define CFS_ADDR 12'hd28
// own registers: interrupt status, mask, captured return pc (read only)
`define IRQ_STAT_ADDR 12'hd40
`define IRQ_MASK_ADDR 12'hd44
`define RET_PC_ADDR 12'hd48
`define ADDR_W 12

// field positions inside the configurable fault status word
`define INVSTATE_BIT 17
`define UNDEFINSTR_BIT 16
`define ADDRVALID_BIT 15
`define RSVD_HI 14
`define RSVD_LO 13

// interrupt status bit positions
`define EV_INVSTATE 0
`define EV_UNDEFINED_INSTR_FLAG 1
`define EV_ADDRVALID 2
`define EV_W 3

`define RESET_WORD 32'h0000_0000
`define RESET_FLAG 1'b0
`define RESET_EV 3'h0

`endif

//--- hdl/sticky_flag.v
`timescale 1ns/1ps
`default_nettype none

// one write-one-to-clear flag; a hardware set beats a clear in the same cycle
module sticky_flag (
  input wire clock,
  input wire sys_rst,
  input wire set_in,
  input wire clr_in,
  output reg flag_r
);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else if (set_in) begin
      flag_r <= 1'b1;
    end else if (clr_in) begin
      flag_r <= 1'b0;
    end
  end

endmodule

`default_nettype wire

//--- hdl/fault_status_bits.v
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fault_status_regs.vh"

// What this block does
// - set invalid-state flag bit 17 on misuse
// - stack misusing instruction address as return
// - no invalid-state flag for undefined instructions
// - set undefined-instruction flag bit 16 on undecodable
// - stack undecodable instruction address as return
// - set address-valid bit 15 when address known
// - address-valid one means address register valid
// - later other fault may clear address-valid
// - writing one clears each flag
// - bits 14:13 reserved, read zero
// - usage group 31:16, bus group 15:8
module fault_status_bits #(
  parameter PC_W = 32
) (
  input wire clock,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire exec_valid,
  input wire [PC_W-1:0] exec_pc,
  input wire status_misuse,
  input wire decode_fail,
  input wire bus_fault,
  input wire bus_fault_addr_known,
  input wire later_fault,
  output reg [PC_W-1:0] return_pc_r,
  output reg return_pc_load_r,
  output wire invalid_state_flag,
  output wire undefined_instr_flag,
  output wire bus_fault_addr_valid,
  output wire fault_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire wr_en;
  wire rd_en;
  wire hit_cfs;
  wire hit_stat;
  wire hit_mask;
  wire hit_pc;
  wire mapped;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign hit_cfs = (paddr == `CFS_ADDR);
  assign hit_stat = (paddr == `IRQ_STAT_ADDR);
  assign hit_mask = (paddr == `IRQ_MASK_ADDR);
  assign hit_pc = (paddr == `RET_PC_ADDR);
  assign mapped = hit_cfs | hit_stat | hit_mask | hit_pc;
  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // byte lanes let each status group be written alone
  wire lane1;
  wire lane2;

  assign lane1 = pstrb[1];
  assign lane2 = pstrb[2];

  ////////////////////////////////////////////////////////////////////////////
  // fault events

  // an undecodable instruction never counts as a status misuse
  wire ev_invstate;
  wire ev_undefined_instr_flag;
  wire ev_addrvalid;
  wire clr_addrvalid_hw;

  assign ev_invstate = exec_valid & status_misuse & ~decode_fail;
  assign ev_undefined_instr_flag = exec_valid & decode_fail;
  assign ev_addrvalid = bus_fault & bus_fault_addr_known;
  // a later non-bus fault may leave the address register stale
  assign clr_addrvalid_hw = later_fault & ~ev_addrvalid;

  ////////////////////////////////////////////////////////////////////////////
  // write-one-to-clear flags

  wire w_cfs;
  wire clr_invstate;
  wire clr_undefined_instr_flag;
  wire clr_addrvalid;

  assign w_cfs = wr_en & hit_cfs;
  assign clr_invstate = w_cfs & lane2 & pwdata[`INVSTATE_BIT];
  assign clr_undefined_instr_flag = w_cfs & lane2 & pwdata[`UNDEFINSTR_BIT];
  // the hard fault handler relies on this clear path
  assign clr_addrvalid = (w_cfs & lane1 & pwdata[`ADDRVALID_BIT])
                         | clr_addrvalid_hw;

  sticky_flag u_invstate (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_in(ev_invstate),
    .clr_in(clr_invstate),
    .flag_r(invalid_state_flag)
  );

  sticky_flag u_undefined_instr_flag (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_in(ev_undefined_instr_flag),
    .clr_in(clr_undefined_instr_flag),
    .flag_r(undefined_instr_flag)
  );

  // reading one here means the bus fault address register is valid
  sticky_flag u_addrvalid (
    .clock(clock),
    .sys_rst(sys_rst),
    .set_in(ev_addrvalid),
    .clr_in(clr_addrvalid),
    .flag_r(bus_fault_addr_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // return address for stacking

  // the faulting instruction itself is returned to, not its successor
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      return_pc_r <= {PC_W{1'b0}};
      return_pc_load_r <= 1'b0;
    end else begin
      return_pc_load_r <= ev_invstate | ev_undefined_instr_flag;
      if (ev_invstate | ev_undefined_instr_flag) begin
        return_pc_r <= exec_pc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  reg [`EV_W-1:0] irq_stat_r;
  reg [`EV_W-1:0] irq_stat_nxt;
  reg [`EV_W-1:0] irq_mask_r;
  wire [`EV_W-1:0] ev_vec;
  wire [`EV_W-1:0] irq_clr;

  assign ev_vec = {ev_addrvalid, ev_undefined_instr_flag, ev_invstate};
  assign irq_clr = (wr_en & hit_stat & pstrb[0]) ?
                   pwdata[`EV_W-1:0] : {`EV_W{1'b0}};

  always @* begin
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | ev_vec;
  end

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_r <= `RESET_EV;
      irq_mask_r <= `RESET_EV;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_en & hit_mask & pstrb[0]) begin
        irq_mask_r <= pwdata[`EV_W-1:0];
      end
    end
  end

  assign fault_irq = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////////
  // read data

  reg [31:0] rd_word;

  always @* begin
    rd_word = `RESET_WORD;
    if (hit_cfs) begin
      rd_word[`INVSTATE_BIT] = invalid_state_flag;
      rd_word[`UNDEFINSTR_BIT] = undefined_instr_flag;
      rd_word[`ADDRVALID_BIT] = bus_fault_addr_valid;
      rd_word[`RSVD_HI:`RSVD_LO] = 2'h0;
    end else if (hit_stat) begin
      rd_word[`EV_W-1:0] = irq_stat_r;
    end else if (hit_mask) begin
      rd_word[`EV_W-1:0] = irq_mask_r;
    end else if (hit_pc) begin
      rd_word = return_pc_r;
    end
  end

  // read data is registered in the setup cycle, valid in the access phase
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= `RESET_WORD;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_word;
    end
  end

endmodule

`default_nettype wire

//--- verif/fault_status_bits_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module fault_status_bits_monitor (
  input wire clock,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire exec_valid,
  input wire status_misuse,
  input wire decode_fail,
  input wire bus_fault,
  input wire bus_fault_addr_known,
  input wire later_fault,
  input wire return_pc_load_r,
  input wire invalid_state_flag,
  input wire undefined_instr_flag,
  input wire bus_fault_addr_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire undefined_instr_flag_ev = exec_valid && decode_fail;
  wire known_bf = bus_fault && bus_fault_addr_known;
  // only byte lane 2 can reach the undefined-instruction flag
  wire clr_undefined_instr_flag = psel && penable && pwrite && paddr == 12'hd28 &&
    pstrb[2] && pwdata[16];
  ////////////////////////////
  a_inv_set: assert property (exec_valid && status_misuse &&
    !decode_fail |=> invalid_state_flag) else $error("inv set");
  a_undefined_instr_flag_set: assert property (undefined_instr_flag_ev |=> undefined_instr_flag)
    else $error("undefined_instr_flag set");
  a_pc_load: assert property (exec_valid && (status_misuse ||
    decode_fail) |=> return_pc_load_r) else $error("pc load");
  a_addr_set: assert property (known_bf |=> bus_fault_addr_valid)
    else $error("addr set");
  a_addr_quiet: assert property (!bus_fault_addr_valid && !known_bf
    |=> !bus_fault_addr_valid) else $error("addr quiet");
  a_later_clr: assert property (later_fault && !known_bf |=>
    !bus_fault_addr_valid) else $error("later clr");
  a_undefined_instr_flag_w1c: assert property (clr_undefined_instr_flag && !undefined_instr_flag_ev |=>
    !undefined_instr_flag) else $error("undefined_instr_flag w1c");
  a_undefined_instr_flag_hold: assert property (undefined_instr_flag && !clr_undefined_instr_flag
    |=> undefined_instr_flag) else $error("undefined_instr_flag hold");
endmodule
bind fault_status_bits fault_status_bits_monitor u_mon (.*);
`default_nettype wire

//--- verif/fault_status_bits_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fault_status_bits_tb;
  logic clock, sys_rst, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, exec_pc, return_pc_r, r, q, p;
  logic [3:0] pstrb;
  logic [5:0] ev;
  logic [2:0] f = 0, st = 0, mk = 0, sm;
  logic exec_valid, status_misuse, decode_fail, bus_fault;
  logic bus_fault_addr_known, later_fault, return_pc_load_r, fault_irq;
  logic invalid_state_flag, undefined_instr_flag, bus_fault_addr_valid;
  int n_fail = 0, n_tests = 0, seed = 32'hf948;
  wire [2:0] fo = {bus_fault_addr_valid, undefined_instr_flag,
    invalid_state_flag};
  assign {exec_valid, status_misuse, decode_fail, bus_fault,
    bus_fault_addr_known, later_fault} = ev;
  fault_status_bits DUT (.*);
  ////////////////////////////
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  initial begin
    #100000;
    n_fail++;
    wrap_up;
  end
  task wrap_up;
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(string n, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task apb(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge clock);
    penable <= 1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clock);
  endtask
  ////////////////////////////
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, pstrb, ev, exec_pc} =
      {1'b1, 89'h0};
    repeat (12) @(posedge clock);
    sys_rst <= 0;
    apb(0, 12'hd28, 0, 0);
    chk("reset cfs", 0, q);
    apb(0, 12'hd3c, 0, 0);
    chk("unmapped err", 1, e);
    chk("pready", 1, pready);
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      p = $random(seed);
      ev <= r[5:0];
      exec_pc <= p;
      @(posedge clock);
      ev <= 0;
      // events never overlap a bus write here, so no priority to model
      sm = {r[2] & r[1], r[5] & r[3], r[5] & r[4] & ~r[3]};
      st = st | sm;
      f = (f | sm) & ~{r[0] & ~sm[2], 2'b0};
      #1;
      chk("flags", f, fo);
      chk("pc load", r[5] & (r[4] | r[3]), return_pc_load_r);
      if (r[5] & (r[4] | r[3])) chk("ret pc", p, return_pc_r);
      // back on a rising edge so the next setup cycle starts on one
      @(posedge clock);
      apb(1, 12'hd28, r, r[9:6]);
      f = f & ~{r[15] & r[7], r[16] & r[8], r[17] & r[8]};
      apb(0, 12'hd28, 0, 0);
      chk("cfs", {14'h0, f[0], f[1], f[2], 15'h0}, q);
      apb(1, 12'hd44, r >> 20, 4'h1);
      mk = r[22:20];
      apb(1, 12'hd40, r >> 24, 4'h1);
      st = st & ~r[26:24];
      apb(0, 12'hd40, 0, 0);
      chk("irq status", st, q);
      chk("irq", |(st & mk), fault_irq);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
